// *** bus_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// single bus master: drives the line and bit slots
// ***************************************************
module bus_master_model #(
  parameter int RST_LEN = 20
) (
  // clock
  input  wire logic                   clk,
  // shared line
  input  wire logic                   dq_oe,
  output logic                        dq_in,
  // bit slot events
  output var netaddr_pkg::slot_evt_t  slot
);
  import netaddr_pkg::*;
  logic rel;

  // pull-up wins unless a party sinks the line (wired-AND)
  assign dq_in = rel & ~dq_oe;
  initial begin
    rel  = 1'b1;
    slot = '0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic drive(input logic v);
    @(posedge clk) rel <= v;
  endtask

  // long low, then time the answer after release
  task automatic bus_reset(output int dly, output int wid);
    dly = 0;
    wid = 0;
    drive(1'b0);
    idle(RST_LEN + 2);
    rel <= 1'b1;
    #1;
    while (dq_in && dly < 1000) begin
      @(posedge clk);
      #1 dly++;
    end
    while (!dq_in && wid < 1000) begin
      @(posedge clk);
      #1 wid++;
    end
    idle(4);
  endtask

  // write slots, lsb first
  task automatic send(input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) begin
        slot.rx_valid <= 1'b1;
        slot.rx_bit   <= v[i];
      end
      @(posedge clk) slot.rx_valid <= 1'b0;
      idle(2);
    end
  endtask

  // read slot; gaps leave room for the registered tx bit
  task automatic recv(output logic b);
    @(posedge clk) slot.read_slot <= 1'b1;
    idle(2);
    #1 b = dq_in;
    @(posedge clk) begin
      slot.read_slot <= 1'b0;
      slot.tx_taken  <= 1'b1;
    end
    @(posedge clk) slot.tx_taken <= 1'b0;
    idle(2);
  endtask
endmodule
`default_nettype wire

// *** netaddr_pkg.sv ***
`default_nettype none
package netaddr_pkg;
  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_PS   = 5000;
  localparam int T_RST_US = 120;
  localparam int T_PDH_US = 15;
  localparam int T_PDL_US = 60;
  localparam int US_PS    = 1000000;
  localparam int RST_CYC  = (T_RST_US*US_PS+CLK_PS-1)/CLK_PS;
  localparam int PDH_CYC  = (T_PDH_US*US_PS+CLK_PS-1)/CLK_PS;
  localparam int PDL_CYC  = (T_PDL_US*US_PS+CLK_PS-1)/CLK_PS;
  localparam int CNT_W    = 16;

  // ***************************************************
  // registers and fields
  // ***************************************************
  localparam logic [7:0] EE_CTRL_ADDR = 8'h07;
  localparam logic [7:0] FEAT_ADDR    = 8'h08;
  localparam int BUSY_BIT  = 7;
  localparam int ARM_BIT   = 6;
  localparam int BLK1_BIT  = 1;
  localparam int BLK0_BIT  = 0;
  localparam int PS_BIT    = 7;
  localparam int PIO_BIT   = 6;
  localparam int SEL_BIT   = 5;
  localparam int OPSEL_DEF = 4;
  localparam int SWAP_ENABLE_DEF  = 3;
  localparam logic [3:0] EE_BLK0_HI = 4'h2;
  localparam logic [3:0] EE_BLK1_HI = 4'h3;

  // ***************************************************
  // address-level opcodes
  // ***************************************************
  localparam logic [7:0] OP_READ0  = 8'h33;
  localparam logic [7:0] OP_READ1  = 8'h39;
  localparam logic [7:0] OP_MATCH  = 8'h55;
  localparam logic [7:0] OP_SKIP   = 8'hcc;
  localparam logic [7:0] OP_SEARCH = 8'hf0;
  localparam logic [7:0] OP_SWAP   = 8'haa;
  localparam int ADDR_BITS = 64;
  // arbitrary family value, not tied to any part
  localparam logic [7:0] FAMILY = 8'h5a;

  typedef struct packed {
    logic rx_valid;   // master write slot done
    logic rx_bit;     // value master wrote
    logic tx_taken;   // master read slot done
    logic read_slot;  // read slot in progress
  } slot_evt_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_t;

  // crc over 56 bits, lsb first, x8+x5+x4+1
  function automatic logic [7:0] crc56(input logic [55:0] d);
    logic [7:0] c;
    logic       fb;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      fb = c[0] ^ d[i];
      c  = {1'b0, c[7:1]} ^ (fb ? 8'h8c : 8'h00);
    end
    return c;
  endfunction

  function automatic logic is_ee(input logic [7:0] a);
    return a[7:4] == EE_BLK0_HI || a[7:4] == EE_BLK1_HI;
  endfunction
endpackage
`default_nettype wire

// *** netaddr_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module netaddr_slave #(
  parameter int          RST_LEN = netaddr_pkg::RST_CYC,
  parameter int          PDH_LEN = netaddr_pkg::PDH_CYC,
  parameter int          PDL_LEN = netaddr_pkg::PDL_CYC,
  parameter logic [47:0] SERIAL  = 48'h0000_0000_0001
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  // shared data line, open drain
  input  wire logic                   dq_in,
  output logic                        dq_out,
  output logic                        dq_oe,
  // bit slot layer
  input  wire netaddr_pkg::slot_evt_t slot,
  output logic                        tx_bit,
  output logic                        func_phase,
  // register access from function layer
  input  wire netaddr_pkg::reg_req_t  rreq,
  output logic [7:0]                  reg_rdata,
  // eeprom write, copy, lock, recall
  input  wire logic                   mem_wr_req,
  input  wire logic [7:0]             mem_wr_addr,
  output logic                        mem_wr_ok,
  input  wire logic                   copy_start,
  input  wire logic [7:0]             copy_addr,
  input  wire logic                   copy_done,
  output logic                        copy_accept,
  input  wire logic                   lock_cmd,
  input  wire logic [7:0]             lock_addr,
  input  wire logic                   recall_status,
  input  wire logic [7:0]             status_default,
  // pack pins
  input  wire logic                   power_switch_sense,
  output logic                        pio_out,
  output logic                        power_enable,
  output logic                        sleep_req
);
  import netaddr_pkg::*;

  localparam logic [63:0] ADDR =
    {crc56({SERIAL, FAMILY}), SERIAL, FAMILY};

  typedef enum logic [3:0] {
    S_WAIT, S_PRES, S_CMD, S_READ, S_MATCH, S_SEARCH,
    S_SWAPP, S_FUNC, S_IGN
  } st_t;

  st_t              st_reg;
  logic [CNT_W-1:0] low_cnt_reg;
  logic [CNT_W-1:0] pres_cnt_reg;
  logic [1:0]       pres_ph_reg;
  logic [7:0]       cmd_reg;
  logic [6:0]       bit_cnt_reg;
  logic [1:0]       srch_ph_reg;
  logic [1:0]       blk_reg;
  logic [7:0]       read_op;
  logic             rst_seen_reg, bus_rst, miss_reg, dq_prev_reg;
  logic             is_swap_reg, busy_reg, arm_reg, opsel_reg;
  logic             swap_enable_reg, sel_reg, cur_bit, lock_go, addr_last;

  assign cur_bit   = ADDR[bit_cnt_reg[5:0]];
  assign addr_last = bit_cnt_reg == 7'(ADDR_BITS - 1);
  assign read_op   = opsel_reg ? OP_READ1 : OP_READ0;

  // ***************************************************
  // reset pulse and presence
  // ***************************************************
  // a low held past the limit ends any transaction
  assign bus_rst = ce && !dq_in && low_cnt_reg == CNT_W'(RST_LEN - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg  <= '0;
      rst_seen_reg <= 1'b0;
    end else if (ce) begin
      if (dq_in) begin
        low_cnt_reg  <= '0;
        rst_seen_reg <= 1'b0;
      end else if (!rst_seen_reg) begin
        low_cnt_reg <= low_cnt_reg + 1'b1;
        if (bus_rst)
          rst_seen_reg <= 1'b1;
      end
    end
  end

  // presence: wait after release, then pull low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pres_cnt_reg <= '0;
      pres_ph_reg  <= 2'd0;
    end else if (ce) begin
      if (rst_seen_reg && dq_in) begin
        pres_ph_reg  <= 2'd1;
        pres_cnt_reg <= '0;
      end else if (pres_ph_reg != 2'd0) begin
        pres_cnt_reg <= pres_cnt_reg + 1'b1;
        if (pres_ph_reg == 2'd1 &&
            pres_cnt_reg == CNT_W'(PDH_LEN - 1)) begin
          pres_ph_reg  <= 2'd2;
          pres_cnt_reg <= '0;
        end else if (pres_ph_reg == 2'd2 &&
                     pres_cnt_reg == CNT_W'(PDL_LEN - 1))
          pres_ph_reg <= 2'd0;
      end
    end
  end

  // open drain: only ever pull low, never drive high
  assign dq_out = 1'b0;
  assign dq_oe  = (pres_ph_reg == 2'd2) ||
                  (slot.read_slot && !tx_bit &&
                   (st_reg == S_READ || st_reg == S_SEARCH));

  // ***************************************************
  // address command sequencer
  // ***************************************************
  // crc byte is sent and matched like any address bit; no crc is computed on received bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg      <= S_WAIT;
      cmd_reg     <= '0;
      bit_cnt_reg <= '0;
      srch_ph_reg <= 2'd0;
      miss_reg    <= 1'b0;
      is_swap_reg <= 1'b0;
    end else if (ce) begin
      if (bus_rst) begin
        st_reg <= S_PRES;
      end else begin
        unique case (st_reg)
          S_PRES: begin
            if (pres_ph_reg == 2'd2 && pres_cnt_reg ==
                CNT_W'(PDL_LEN - 1)) begin
              st_reg      <= S_CMD;
              bit_cnt_reg <= '0;
            end
          end
          S_CMD: begin
            if (slot.rx_valid) begin
              cmd_reg     <= {slot.rx_bit, cmd_reg[7:1]};
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
              if (bit_cnt_reg == 7'd7) begin
                bit_cnt_reg <= '0;
                srch_ph_reg <= 2'd0;
                miss_reg    <= 1'b0;
                unique case ({slot.rx_bit, cmd_reg[7:1]})
                  read_op:   st_reg <= S_READ;
                  OP_MATCH:  begin
                    st_reg      <= S_MATCH;
                    is_swap_reg <= 1'b0;
                  end
                  OP_SKIP:   st_reg <= S_FUNC;
                  OP_SEARCH: st_reg <= S_SEARCH;
                  OP_SWAP:   begin
                    st_reg <= swap_enable_reg ? S_MATCH : S_IGN;
                    is_swap_reg <= 1'b1;
                  end
                  default:   st_reg <= S_IGN;
                endcase
              end
            end
          end
          S_READ: begin
            if (slot.tx_taken) begin
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
              if (addr_last)
                st_reg <= S_FUNC;
            end
          end
          S_MATCH: begin
            if (slot.rx_valid) begin
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
              if (slot.rx_bit != cur_bit)
                miss_reg <= 1'b1;
              if (addr_last) begin
                if (is_swap_reg)
                  st_reg <= S_SWAPP;
                else if (miss_reg || slot.rx_bit != cur_bit)
                  st_reg <= S_IGN;
                else
                  st_reg <= S_FUNC;
              end
            end
          end
          S_SEARCH: begin
            if (srch_ph_reg != 2'd2 && slot.tx_taken)
              srch_ph_reg <= srch_ph_reg + 1'b1;
            else if (srch_ph_reg == 2'd2 && slot.rx_valid) begin
              srch_ph_reg <= 2'd0;
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
              if (slot.rx_bit != cur_bit)
                st_reg <= S_IGN;
              else if (addr_last)
                st_reg <= S_FUNC;
            end
          end
          S_SWAPP: begin
            if (dq_in && !dq_prev_reg)
              st_reg <= S_IGN;
          end
          S_WAIT, S_FUNC, S_IGN: ;
        endcase
      end
    end
  end

  // search sends bit then complement; read sends bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      tx_bit <= 1'b1;
    else if (ce)
      tx_bit <= (st_reg == S_SEARCH && srch_ph_reg == 2'd1) ?
                !cur_bit : cur_bit;
  end

  assign func_phase = st_reg == S_FUNC;

  // ***************************************************
  // swap power sequencing
  // ***************************************************
  // break before make: everyone drops on the fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_prev_reg  <= 1'b1;
      power_enable <= 1'b1;
      sel_reg      <= 1'b0;
      sleep_req    <= 1'b0;
    end else if (ce) begin
      dq_prev_reg <= dq_in;
      if (bus_rst)
        sleep_req <= 1'b0;
      if (st_reg == S_SWAPP) begin
        if (!dq_in && dq_prev_reg)
          power_enable <= 1'b0;
        else if (dq_in && !dq_prev_reg) begin
          power_enable <= !miss_reg;
          sel_reg      <= !miss_reg;
          sleep_req    <= miss_reg;
        end
      end
    end
  end

  // ***************************************************
  // eeprom control: copy, lock, write gating
  // ***************************************************
  assign copy_accept = copy_start && is_ee(copy_addr) &&
                       !busy_reg && !blk_reg[copy_addr[4]];
  assign lock_go     = lock_cmd && arm_reg && is_ee(lock_addr);
  // busy or locked blocks refuse eeprom writes only
  assign mem_wr_ok   = mem_wr_req && !(is_ee(mem_wr_addr) &&
                       (busy_reg || blk_reg[mem_wr_addr[4]]));

  // a new copy in the done cycle is refused while busy is set, so busy clears
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      busy_reg <= 1'b0;
    else if (ce) begin
      if (copy_accept)
        busy_reg <= 1'b1;
      else if (copy_done)
        busy_reg <= 1'b0;
    end
  end

  // lock flags never clear once set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_reg <= 1'b0;
      blk_reg <= 2'b00;
    end else if (ce) begin
      if (lock_go) begin
        blk_reg[lock_addr[4]] <= 1'b1;
        arm_reg <= 1'b0;
      end else if (rreq.wr && rreq.addr == EE_CTRL_ADDR)
        arm_reg <= rreq.data[ARM_BIT];
    end
  end

  // status bits load from eeprom defaults only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opsel_reg <= 1'b0;
      swap_enable_reg  <= 1'b0;
    end else if (ce && recall_status) begin
      opsel_reg <= status_default[OPSEL_DEF];
      swap_enable_reg  <= status_default[SWAP_ENABLE_DEF];
    end
  end

  // programmable pin is the one writable feature bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pio_out <= 1'b0;
    else if (ce && rreq.wr && rreq.addr == FEAT_ADDR)
      pio_out <= rreq.data[PIO_BIT];
  end

  // ***************************************************
  // register read
  // ***************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (ce) begin
      reg_rdata <= 8'h00;
      if (rreq.addr == EE_CTRL_ADDR) begin
        reg_rdata[BUSY_BIT] <= busy_reg;
        reg_rdata[ARM_BIT]  <= arm_reg;
        reg_rdata[BLK1_BIT] <= blk_reg[1];
        reg_rdata[BLK0_BIT] <= blk_reg[0];
      end else if (rreq.addr == FEAT_ADDR) begin
        reg_rdata[PS_BIT]  <= power_switch_sense;
        reg_rdata[PIO_BIT] <= pio_out;
        reg_rdata[SEL_BIT] <= sel_reg;
      end
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_BUSY_WR: assert property (
    mem_wr_req && busy_reg && is_ee(mem_wr_addr) |-> !mem_wr_ok)
    else $error("eeprom write passed while copy busy");
  AST_ARM_CLR: assert property (ce && lock_go |=> !arm_reg)
    else $error("lock arm did not clear after lock");
  AST_LOCK_NEED_ARM: assert property (
    ce && lock_cmd && !arm_reg |=> blk_reg == $past(blk_reg))
    else $error("lock took effect without arm");
  AST_LOCK_STAYS: assert property (blk_reg[1] |=> blk_reg[1])
    else $error("block lock flag cleared");
  AST_PS_MIRROR: assert property (
    ce && rreq.addr == FEAT_ADDR |=>
    reg_rdata[PS_BIT] == $past(power_switch_sense))
    else $error("sense bit does not mirror pin");
  AST_OD: assert property (dq_out == 1'b0 &&
    (!dq_oe || pres_ph_reg == 2'd2 || slot.read_slot))
    else $error("data line driven high or out of turn");
  AST_RST: assert property (bus_rst |=> st_reg == S_PRES)
    else $error("long low did not restart sequence");
  AST_SWAP_OFF: assert property (
    ce && !swap_enable_reg && st_reg == S_CMD |=>
    !(st_reg == S_MATCH && is_swap_reg))
    else $error("swap taken while disabled");
  AST_FALL_OFF: assert property (
    ce && st_reg == S_SWAPP && !dq_in && dq_prev_reg |=> !power_enable)
    else $error("power not dropped on swap fall");
  AST_SEARCH_OUT: assert property (
    ce && st_reg == S_SEARCH && srch_ph_reg == 2'd2 && slot.rx_valid &&
    slot.rx_bit != cur_bit && !bus_rst |=> st_reg == S_IGN)
    else $error("search mismatch did not drop out");

  COV_MATCH: cover property (st_reg == S_MATCH ##[1:1000]
    st_reg == S_FUNC);
  COV_SEARCH: cover property (st_reg == S_SEARCH && addr_last);
  COV_SWAP: cover property (st_reg == S_SWAPP ##1 sel_reg);
  COV_COPY: cover property (copy_accept ##[1:100] copy_done);
endmodule
`default_nettype wire

// *** single_wire_net_address_slave_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// bench: presence, address commands, registers
// ***************************************************
module single_wire_net_address_slave_bench;
  import netaddr_pkg::*;
  localparam int          RL  = 20;
  localparam int          PH  = 5;
  localparam int          PL  = 10;
  localparam logic [47:0] SER = 48'h1234_5678_9abc;
  logic       clk, rst_n, dq_in, dq_out, dq_oe, tx_bit, func_phase;
  logic       mem_wr_req, mem_wr_ok, copy_start, copy_done, copy_accept;
  logic       lock_cmd, recall_status, power_switch_sense, pio_out;
  logic       power_enable, sleep_req, ce;
  logic [7:0] reg_rdata, mem_wr_addr, copy_addr, lock_addr;
  logic [7:0] status_default, rd;
  logic [1:0] ok;
  logic [63:0] me;
  slot_evt_t  slot;
  reg_req_t   rreq;
  int         fails, checks, d, w;

  netaddr_slave #(.RST_LEN(RL), .PDH_LEN(PH), .PDL_LEN(PL), .SERIAL(SER))
    i_netaddr_slave (.clk(clk), .rst_n(rst_n), .ce(ce), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .slot(slot), .tx_bit(tx_bit),
    .func_phase(func_phase), .rreq(rreq), .reg_rdata(reg_rdata),
    .mem_wr_req(mem_wr_req), .mem_wr_addr(mem_wr_addr),
    .mem_wr_ok(mem_wr_ok), .copy_start(copy_start), .copy_addr(copy_addr),
    .copy_done(copy_done), .copy_accept(copy_accept), .lock_cmd(lock_cmd),
    .lock_addr(lock_addr), .recall_status(recall_status),
    .status_default(status_default),
    .power_switch_sense(power_switch_sense), .pio_out(pio_out),
    .power_enable(power_enable), .sleep_req(sleep_req));
  bus_master_model #(.RST_LEN(RL)) i_bus_master_model (.clk(clk),
    .dq_oe(dq_oe), .dq_in(dq_in), .slot(slot));

  // host-side crc, lsb first from zero
  function automatic logic [7:0] addr_crc(input logic [55:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++)
      c = {1'b0, c[7:1]} ^ ((c[0] ^ v[i]) ? 8'h8c : 8'h00);
    return c;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic rg(input logic [7:0] a, input logic we, input logic [7:0] v);
    @(posedge clk) rreq <= '{wr: we, addr: a, data: v};
    @(posedge clk) rreq.wr <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  // pulses copy start / copy done / lock, probes accept and write gate
  task automatic ctl(input logic [2:0] p, input logic [7:0] a);
    @(posedge clk) begin
      {copy_start, copy_done, lock_cmd} <= p;
      copy_addr   <= a;
      lock_addr   <= a;
      mem_wr_addr <= a;
      mem_wr_req  <= 1'b1;
    end
    #1 ok = {copy_accept, mem_wr_ok};
    @(posedge clk) begin
      {copy_start, copy_done, lock_cmd} <= 3'b000;
      mem_wr_req <= 1'b0;
    end
  endtask

  task automatic recall(input logic [7:0] v);
    @(posedge clk) begin
      recall_status  <= 1'b1;
      status_default <= v;
    end
    @(posedge clk) recall_status <= 1'b0;
  endtask

  task automatic start(input logic [7:0] op);
    i_bus_master_model.bus_reset(d, w);
    i_bus_master_model.send({56'h0, op}, 8);
  endtask

  task automatic t_presence();
    i_bus_master_model.bus_reset(d, w);
    chk(w, PL);
    chk(d >= PH && d <= PH + 4, 1);
  endtask

  task automatic t_read(input logic [7:0] op, input logic [63:0] exp);
    logic [63:0] got;
    logic        b;
    start(op);
    for (int i = 0; i < 64; i++) begin
      i_bus_master_model.recv(b);
      got[i] = b;
    end
    chk(got, exp);
    chk(dq_out, 0);
  endtask

  task automatic t_op(input logic [7:0] op, input logic [63:0] a,
                      input int n, input logic exp);
    start(op);
    i_bus_master_model.send(a, n);
    i_bus_master_model.idle(2);
    chk(func_phase, exp);
  endtask

  task automatic t_search(input int k);
    logic b0, b1;
    start(OP_SEARCH);
    for (int i = 0; i < 64; i++) begin
      i_bus_master_model.recv(b0);
      i_bus_master_model.recv(b1);
      chk({b0, b1}, (i > k) ? 2'b11 : {me[i], ~me[i]});
      i_bus_master_model.send({63'h0, me[i] ^ (i == k)}, 1);
    end
  endtask

  task automatic t_swap(input logic [63:0] a, input logic en, input logic sel);
    start(OP_SWAP);
    i_bus_master_model.send(a, 64);
    i_bus_master_model.drive(1'b0);
    i_bus_master_model.idle(3);
    chk(power_enable, !en);
    i_bus_master_model.drive(1'b1);
    i_bus_master_model.idle(3);
    chk(power_enable, !en | sel);
    chk(sleep_req, en & !sel);
    rg(FEAT_ADDR, 1'b0, 8'h00);
    chk(rd[SEL_BIT], en & sel);
  endtask

  task automatic t_regs();
    rg(EE_CTRL_ADDR, 1'b0, 8'h00);
    chk(rd, 8'h00);
    rg(8'h09, 1'b0, 8'h00);
    chk(rd, 8'h00);
    ctl(3'b000, 8'h26);
    chk(ok, 2'b01);
    ctl(3'b100, 8'h25);
    chk(ok[1], 1);
    ctl(3'b000, 8'h26);
    chk(ok[0], 0);
    ctl(3'b000, 8'h80);
    chk(ok[0], 1);
    rg(EE_CTRL_ADDR, 1'b0, 8'h00);
    chk(rd, 8'h80);
    ctl(3'b010, 8'h00);
    ctl(3'b001, 8'h20);
    rg(EE_CTRL_ADDR, 1'b1, 8'hff);
    rg(EE_CTRL_ADDR, 1'b0, 8'h00);
    chk(rd, 8'h40);
    ctl(3'b001, 8'h35);
    rg(EE_CTRL_ADDR, 1'b0, 8'h00);
    chk(rd, 8'h02);
    rg(EE_CTRL_ADDR, 1'b1, 8'h40);
    ctl(3'b001, 8'h20);
    rg(EE_CTRL_ADDR, 1'b0, 8'h00);
    chk(rd, 8'h03);
    ctl(3'b000, 8'h21);
    chk(ok[0], 0);
    ctl(3'b100, 8'h31);
    chk(ok[1], 0);
  endtask

  task automatic t_feature();
    @(posedge clk) power_switch_sense <= 1'b1;
    rg(FEAT_ADDR, 1'b0, 8'h00);
    chk(rd[PS_BIT], 1);
    @(posedge clk) power_switch_sense <= 1'b0;
    rg(FEAT_ADDR, 1'b0, 8'h00);
    chk(rd[PS_BIT], 0);
    rg(FEAT_ADDR, 1'b1, 8'hc0);
    i_bus_master_model.idle(1);
    chk(pio_out, 1);
  endtask

  // enable low: a feature write must not land
  task automatic t_freeze();
    @(posedge clk) ce <= 1'b0;
    rg(FEAT_ADDR, 1'b1, 8'h00);
    chk(pio_out, 1);
    @(posedge clk) ce <= 1'b1;
    i_bus_master_model.idle(1);
    chk(pio_out, 1);
  endtask

  // mid-run reset: back to idle, ignores bus until a reset pulse
  task automatic t_reset();
    t_op(OP_SKIP, 64'h0, 0, 1'b1);
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk);
    chk({power_enable, sleep_req, pio_out, func_phase, reg_rdata}, 12'h800);
    @(posedge clk) rst_n <= 1'b1;
    i_bus_master_model.send({56'h0, OP_SKIP}, 8);
    i_bus_master_model.idle(2);
    chk(func_phase, 0);
    t_presence();
    t_op(OP_SKIP, 64'h0, 0, 1'b1);
  endtask

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard, well past the expected run
  initial begin
    #400000;
    fails++;
    summarize();
  end

  // main sequence
  initial begin
    me = {addr_crc({SER, FAMILY}), SER, FAMILY};
    {rst_n, mem_wr_req, copy_start, copy_done, lock_cmd} = '0;
    {recall_status, power_switch_sense} = '0;
    {mem_wr_addr, copy_addr, lock_addr, status_default} = '0;
    rreq = '0;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    recall(8'h00);
    t_presence();
    t_read(OP_READ0, me);
    recall(8'h10);
    t_read(OP_READ1, me);
    t_read(OP_READ0, {64{1'b1}});
    t_op(OP_SKIP, 64'h0, 0, 1'b1);
    t_op(8'h77, 64'h0, 0, 1'b0);
    t_op(OP_MATCH, me, 64, 1'b1);
    t_op(OP_MATCH, me ^ (64'h1 << 40), 64, 1'b0);
    t_search(64);
    t_search(5);
    t_swap(me, 1'b0, 1'b0);
    recall(8'h08);
    t_swap(me ^ 64'h2, 1'b1, 1'b0);
    t_swap(me, 1'b1, 1'b1);
    t_regs();
    t_feature();
    t_freeze();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
